// ### srcl_pkg.sv
// constants, register map and state encoding of the serial ROM config loader
// assumes: byte entries arrive from a serial ROM reader as offset/data pairs
package srcl_pkg;
  // ----------------------------------------
  // entry layout
  // ----------------------------------------
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned ENTRY_W = 16;
  localparam int unsigned FIFO_DEPTH = 4;
  // ----------------------------------------
  // serial ROM offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_FORCE_EVT = 8'h1C;
  localparam logic [7:0] OFF_LEGACY_ID = 8'h1D;
  localparam logic [7:0] OFF_OHCI_IND = 8'h22;
  localparam logic [7:0] OFF_OHCI_CNT = 8'h23;
  localparam logic [7:0] OFF_LAT_GNT = 8'h24;
  localparam logic [7:0] OFF_LINK_BITS = 8'h29;
  localparam logic [7:0] OFF_MINI_ROM = 8'h2A;
  localparam logic [7:0] OFF_PHY_CTRL = 8'h3A;
  localparam logic [7:0] OFF_SC_IND = 8'h4F;
  localparam logic [7:0] OFF_SC_CNT = 8'h50;
  localparam logic [7:0] OFF_SC_CLASS0 = 8'h51;
  localparam logic [7:0] OFF_SC_CLASS2 = 8'h53;
  localparam logic [7:0] OFF_SC_SSVID0 = 8'h54;
  localparam logic [7:0] OFF_SC_SSVID1 = 8'h55;
  localparam logic [7:0] OFF_SC_SSID0 = 8'h56;
  localparam logic [7:0] OFF_SC_SSID1 = 8'h57;
  localparam logic [7:0] OFF_SC_GCTRL = 8'h58;
  localparam logic [7:0] OFF_SC_CFG1_0 = 8'h59;
  localparam logic [7:0] OFF_SC_CFG1_3 = 8'h5C;
  localparam logic [7:0] OFF_SC_CFG2_0 = 8'h5D;
  localparam logic [7:0] OFF_SC_CFG2_1 = 8'h5E;
  localparam logic [7:0] OFF_END = 8'h5F;
  // ----------------------------------------
  // marker values and field positions
  // ----------------------------------------
  localparam logic [7:0] IND_OHCI = 8'h02;
  localparam logic [7:0] IND_SC = 8'h05;
  localparam logic [7:0] CNT_SC = 8'h0E;
  localparam logic [7:0] END_MARK = 8'h80;
  localparam logic [7:0] MINI_NONE = 8'h00;
  localparam logic [7:0] PHY_CTRL_MASK = 8'h8A;
  localparam int unsigned FORCE_SRC_BIT = 3;
  localparam int unsigned LINK_UNFAIR_BIT = 7;
  localparam int unsigned LINK_PHYPROG_BIT = 6;
  localparam int unsigned LINK_ENH2_BIT = 2;
  localparam int unsigned LINK_ACCEL_BIT = 1;
  localparam int unsigned SC_GCTRL_W = 7;
  // ----------------------------------------
  // software register map
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_SC_CLASS = 8'h08;
  localparam logic [7:0] REG_SC_IDS = 8'h0C;
  localparam logic [7:0] REG_SC_CFG1 = 8'h10;
  localparam logic [7:0] REG_SC_CFG2 = 8'h14;
  localparam logic [7:0] REG_OHCI = 8'h18;
  localparam logic [7:0] REG_LEGACY = 8'h1C;
  localparam int unsigned CTRL_LOAD_EN_BIT = 0;
  localparam int unsigned CTRL_RESTART_BIT = 1;
  localparam logic CTRL_LOAD_EN_RST = 1'b1;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  // ----------------------------------------
  // loader states
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_DONE = 2'b10
  } srcl_state_e;
endpackage

// ### srcl_stream_if.sv
// valid/ready byte-entry stream between the loader and its FIFO
// assumes: one clock, data held while valid and not ready
interface srcl_stream_if #(parameter int unsigned W = 16);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ### srcl_fifo.sv
// small synchronous FIFO for ROM entries, registered flags
// assumes: single clock domain, clock enable freezes all state
module srcl_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 4
) (
  input wire logic clk, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic ce, // clock enable
  srcl_stream_if.snk in_s, // fill side
  srcl_stream_if.src out_s // drain side
);
  localparam int unsigned AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("srcl_fifo depth must be a power of two of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0] cnt_reg;
  logic [AW:0] cnt_next;
  logic ready_reg;
  logic valid_reg;
  logic push;
  logic pop;

  assign push = ce && in_s.valid && ready_reg;
  assign pop = ce && out_s.ready && valid_reg;
  assign cnt_next = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign in_s.ready = ready_reg;
  assign out_s.valid = valid_reg;
  assign out_s.data = mem_reg[rp_reg];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wp_reg] <= in_s.data;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
      ready_reg <= 1'b0;
      valid_reg <= 1'b0;
    end else if (ce) begin
      if (push) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (pop) begin
        rp_reg <= rp_reg + 1'b1;
      end
      cnt_reg <= cnt_next;
      ready_reg <= cnt_next < (AW+1)'(DEPTH);
      valid_reg <= cnt_next != '0;
    end
  end
endmodule

// ### srcl_loader.sv
// serial ROM configuration loader: decodes offset/byte entries into config bits
// assumes: an external reader delivers entries in ascending offset order
//
// Design decisions made here: the plain strobed port and the register addresses.

// Summary of operation
// - Bit 3 of byte 1Ch sets socket force-event bit 27; rest ignored.
// - Whole byte 1Dh goes to legacy socket identification/revision register.
// - Byte 24h: upper nibble max latency, lower nibble min grant.
// - Byte 2Ah is mini ROM pointer; 00h means none present.
// - Byte 3Ah loads only bits 7, 3 and 1 of PHY control.
// - Smart card section starts at 4Fh with indicator 05h.
// - Count 0Eh follows indicator; marker 80h at 5Fh stops loading.
// - Offsets 51h-53h load class code bytes 0 to 2.
// - 54h/55h subsystem vendor id, 56h/57h subsystem id, low first.
// - Byte 58h bits 6-0 load general control; bit 7 dropped.
// - Offsets 59h-5Ch load config register 1 bytes 0 to 3.
// - Offsets 5Dh/5Eh load config register 2 bytes 0 and 1.
module srcl_loader (
  input wire logic clk, // system clock, 50 MHz
  input wire logic rst_b, // async reset, active low
  input wire logic ce, // clock enable, freezes state when low
  input wire logic rom_valid, // entry from ROM reader valid
  input wire logic [7:0] rom_offset, // serial ROM offset of entry
  input wire logic [7:0] rom_data, // serial ROM byte
  output logic rom_ready, // loader can take an entry
  input wire logic [7:0] addr, // register byte address
  input wire logic [31:0] wr_data, // register write data
  input wire logic wr_en, // write strobe
  input wire logic rd_en, // read strobe
  output logic [31:0] rd_data, // read data, cycle after strobe
  output logic load_done, // end-of-list reached
  output logic force_evt_b27, // socket force event bit 27
  output logic [7:0] legacy_id_rev, // legacy socket id/revision
  output logic [3:0] max_lat, // 1394 maximum latency
  output logic [3:0] min_gnt, // 1394 minimum grant
  output logic unfair_en, // link unfair mode enable
  output logic phy_prog_permit, // host_controller_control bit 23
  output logic link_enh2, // link enhancement bit 2
  output logic accel_en, // link acceleration enable
  output logic [7:0] mini_rom_ptr, // mini ROM offset
  output logic mini_rom_present, // mini ROM pointer non-zero
  output logic [7:0] phy_ctrl, // PHY control config bits
  output logic [23:0] sc_class, // smart card class code
  output logic [15:0] sc_ssvid, // smart card subsystem vendor id
  output logic [15:0] sc_ssid, // smart card subsystem id
  output logic [srcl_pkg::SC_GCTRL_W-1:0] sc_gen_ctrl, // smart card general control
  output logic [31:0] sc_cfg1, // smart card configuration 1
  output logic [15:0] sc_cfg2 // smart card configuration 2
);
  import srcl_pkg::*;

  // ----------------------------------------
  // entry FIFO
  // ----------------------------------------
  srcl_stream_if #(.W(ENTRY_W)) in_if ();
  srcl_stream_if #(.W(ENTRY_W)) out_if ();

  assign in_if.valid = rom_valid;
  assign in_if.data = {rom_offset, rom_data};
  assign rom_ready = in_if.ready;

  srcl_fifo #(.WIDTH(ENTRY_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .in_s(in_if.snk),
    .out_s(out_if.src)
  );

  srcl_state_e state_reg;
  logic load_en_reg;
  logic restart;
  logic pop;
  logic [7:0] off;
  logic [7:0] byt;

  assign restart = wr_en && addr == REG_CTRL && wr_data[CTRL_RESTART_BIT];
  assign out_if.ready = state_reg == ST_LOAD;
  assign pop = ce && out_if.valid && out_if.ready;
  assign off = out_if.data[15:8];
  assign byt = out_if.data[7:0];

  // ----------------------------------------
  // section tracking
  // ----------------------------------------
  logic ohci_ok_reg;
  logic [7:0] ohci_last_reg;
  logic sc_ind_reg;
  logic sc_ok_reg;
  logic [7:0] sc_last_reg;
  logic fmt_err_reg;
  logic in_ohci;
  logic in_sc;
  logic end_hit;

  assign in_ohci = ohci_ok_reg && off > OFF_OHCI_CNT && off <= ohci_last_reg;
  assign in_sc = sc_ok_reg && off > OFF_SC_CNT && off <= sc_last_reg;
  assign end_hit = pop && off == OFF_END && byt == END_MARK;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ohci_ok_reg <= 1'b0;
      ohci_last_reg <= BYTE_RST;
      sc_ind_reg <= 1'b0;
      sc_ok_reg <= 1'b0;
      sc_last_reg <= BYTE_RST;
      fmt_err_reg <= 1'b0;
    end else if (ce) begin
      if (restart) begin
        ohci_ok_reg <= 1'b0;
        sc_ind_reg <= 1'b0;
        sc_ok_reg <= 1'b0;
        fmt_err_reg <= 1'b0;
      end
      // entry seen in the same cycle as restart wins
      if (pop) begin
        if (off == OFF_OHCI_IND) begin
          ohci_ok_reg <= 1'b0;
          sc_ind_reg <= 1'b0;
          if (byt != IND_OHCI) begin
            fmt_err_reg <= 1'b1;
          end
        end
        if (off == OFF_OHCI_CNT) begin
          ohci_ok_reg <= 1'b1;
          ohci_last_reg <= OFF_OHCI_CNT + byt;
        end
        if (off == OFF_SC_IND) begin
          sc_ind_reg <= byt == IND_SC;
          if (byt != IND_SC) begin
            fmt_err_reg <= 1'b1;
          end
        end
        if (off == OFF_SC_CNT) begin
          sc_ok_reg <= sc_ind_reg;
          sc_last_reg <= OFF_SC_CNT + byt;
          if (byt != CNT_SC) begin
            fmt_err_reg <= 1'b1;
          end
        end
        if (off == OFF_END && byt != END_MARK) begin
          fmt_err_reg <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // control state
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      load_done <= 1'b0;
    end else if (ce) begin
      case (state_reg)
        ST_IDLE: begin
          if (load_en_reg) begin
            state_reg <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (end_hit) begin
            state_reg <= ST_DONE;
            load_done <= 1'b1;
          end else if (!load_en_reg) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_DONE: begin
          if (restart) begin
            state_reg <= ST_IDLE;
            load_done <= 1'b0;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // socket and legacy register loads
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      force_evt_b27 <= 1'b0;
      legacy_id_rev <= BYTE_RST;
    end else if (pop) begin
      if (off == OFF_FORCE_EVT) begin
        force_evt_b27 <= byt[FORCE_SRC_BIT];
      end
      if (off == OFF_LEGACY_ID) begin
        legacy_id_rev <= byt;
      end
    end
  end

  // ----------------------------------------
  // 1394 function loads
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      max_lat <= 4'h0;
      min_gnt <= 4'h0;
      unfair_en <= 1'b0;
      phy_prog_permit <= 1'b0;
      link_enh2 <= 1'b0;
      accel_en <= 1'b0;
      mini_rom_ptr <= MINI_NONE;
      mini_rom_present <= 1'b0;
      phy_ctrl <= BYTE_RST;
    end else if (pop && in_ohci) begin
      if (off == OFF_LAT_GNT) begin
        max_lat <= byt[7:4];
        min_gnt <= byt[3:0];
      end
      if (off == OFF_LINK_BITS) begin
        unfair_en <= byt[LINK_UNFAIR_BIT];
        phy_prog_permit <= byt[LINK_PHYPROG_BIT];
        link_enh2 <= byt[LINK_ENH2_BIT];
        accel_en <= byt[LINK_ACCEL_BIT];
      end
      if (off == OFF_MINI_ROM) begin
        mini_rom_ptr <= byt;
        mini_rom_present <= byt != MINI_NONE;
      end
      if (off == OFF_PHY_CTRL) begin
        phy_ctrl <= (phy_ctrl & ~PHY_CTRL_MASK) | (byt & PHY_CTRL_MASK);
      end
    end
  end

  // ----------------------------------------
  // smart card function loads
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sc_class <= '0;
      sc_ssvid <= '0;
      sc_ssid <= '0;
      sc_gen_ctrl <= '0;
      sc_cfg1 <= '0;
      sc_cfg2 <= '0;
    end else if (pop && in_sc) begin
      if (off >= OFF_SC_CLASS0 && off <= OFF_SC_CLASS2) begin
        sc_class[8*(2'(off - OFF_SC_CLASS0)) +: 8] <= byt;
      end
      if (off == OFF_SC_SSVID0) begin
        sc_ssvid[7:0] <= byt;
      end
      if (off == OFF_SC_SSVID1) begin
        sc_ssvid[15:8] <= byt;
      end
      if (off == OFF_SC_SSID0) begin
        sc_ssid[7:0] <= byt;
      end
      if (off == OFF_SC_SSID1) begin
        sc_ssid[15:8] <= byt;
      end
      if (off == OFF_SC_GCTRL) begin
        sc_gen_ctrl <= byt[SC_GCTRL_W-1:0];
      end
      if (off >= OFF_SC_CFG1_0 && off <= OFF_SC_CFG1_3) begin
        sc_cfg1[8*(2'(off - OFF_SC_CFG1_0)) +: 8] <= byt;
      end
      if (off == OFF_SC_CFG2_0) begin
        sc_cfg2[7:0] <= byt;
      end
      if (off == OFF_SC_CFG2_1) begin
        sc_cfg2[15:8] <= byt;
      end
    end
  end

  // ----------------------------------------
  // register port
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      load_en_reg <= CTRL_LOAD_EN_RST;
    end else if (ce && wr_en && addr == REG_CTRL) begin
      load_en_reg <= wr_data[CTRL_LOAD_EN_BIT];
    end
  end

  logic [31:0] rd_next;

  always_comb begin
    rd_next = WORD_ZERO;
    if (addr == REG_CTRL) begin
      rd_next = {31'h0000_0000, load_en_reg};
    end else if (addr == REG_STATUS) begin
      rd_next = {26'h000_0000, state_reg, fmt_err_reg, sc_ok_reg, ohci_ok_reg, load_done};
    end else if (addr == REG_SC_CLASS) begin
      rd_next = {8'h00, sc_class};
    end else if (addr == REG_SC_IDS) begin
      rd_next = {sc_ssid, sc_ssvid};
    end else if (addr == REG_SC_CFG1) begin
      rd_next = sc_cfg1;
    end else if (addr == REG_SC_CFG2) begin
      rd_next = {9'h000, sc_gen_ctrl, sc_cfg2};
    end else if (addr == REG_OHCI) begin
      rd_next = {mini_rom_present, unfair_en, phy_prog_permit, link_enh2, accel_en, 3'h0,
                 mini_rom_ptr, phy_ctrl, max_lat, min_gnt};
    end else if (addr == REG_LEGACY) begin
      rd_next = {23'h00_0000, force_evt_b27, legacy_id_rev};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= WORD_ZERO;
    end else if (ce) begin
      rd_data <= rd_en ? rd_next : WORD_ZERO;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_force_bit: assert property (@(posedge clk) disable iff (!rst_b)
    pop && off == OFF_FORCE_EVT |=> force_evt_b27 == $past(byt[FORCE_SRC_BIT]))
    else $error("force event bit not taken from bit 3");
  a_legacy_byte: assert property (@(posedge clk) disable iff (!rst_b)
    pop && off == OFF_LEGACY_ID |=> legacy_id_rev == $past(byt))
    else $error("legacy id byte not loaded");
  a_lat_gnt: assert property (@(posedge clk) disable iff (!rst_b)
    pop && in_ohci && off == OFF_LAT_GNT |=> {max_lat, min_gnt} == $past(byt))
    else $error("latency and grant nibbles wrong");
  a_link_bits: assert property (@(posedge clk) disable iff (!rst_b)
    pop && in_ohci && off == OFF_LINK_BITS
    |=> {unfair_en, phy_prog_permit, link_enh2, accel_en}
        == {$past(byt[7]), $past(byt[6]), $past(byt[2]), $past(byt[1])})
    else $error("link bits wrong");
  a_mini_rom: assert property (@(posedge clk) disable iff (!rst_b)
    mini_rom_present == (mini_rom_ptr != MINI_NONE))
    else $error("mini rom presence disagrees with pointer");
  a_phy_mask: assert property (@(posedge clk) disable iff (!rst_b)
    (phy_ctrl & ~PHY_CTRL_MASK) == 8'h00)
    else $error("phy control bit outside mask loaded");
  a_end_stop: assert property (@(posedge clk) disable iff (!rst_b)
    end_hit |=> load_done && !out_if.ready ##1 !pop)
    else $error("loading did not stop at end marker");
  a_sc_gate: assert property (@(posedge clk) disable iff (!rst_b)
    $changed(sc_class) |-> $past(sc_ok_reg))
    else $error("smart card entry loaded without indicator");
  a_ssvid_low: assert property (@(posedge clk) disable iff (!rst_b)
    pop && in_sc && off == OFF_SC_SSVID0 |=> sc_ssvid[7:0] == $past(byt))
    else $error("subsystem vendor id low byte wrong");
  a_gctrl: assert property (@(posedge clk) disable iff (!rst_b)
    pop && in_sc && off == OFF_SC_GCTRL |=> sc_gen_ctrl == $past(byt[6:0]))
    else $error("general control bits wrong");
  a_cfg1_top: assert property (@(posedge clk) disable iff (!rst_b)
    pop && in_sc && off == OFF_SC_CFG1_3 |=> sc_cfg1[31:24] == $past(byt))
    else $error("config 1 byte 3 wrong");
  a_cfg2_high: assert property (@(posedge clk) disable iff (!rst_b)
    pop && in_sc && off == OFF_SC_CFG2_1 |=> sc_cfg2[15:8] == $past(byt))
    else $error("config 2 byte 1 wrong");
  a_ohci_bound: assert property (@(posedge clk) disable iff (!rst_b)
    $changed(max_lat) |-> $past(ohci_ok_reg) && $past(off) > OFF_OHCI_CNT)
    else $error("1394 entry loaded outside its section");
endmodule

// ### srcl_rom_model.sv
// serial ROM partner: offers the byte image as ascending offset/data entries
// assumes: valid/ready stream, entry taken on a clock-enabled edge with ready high
module srcl_rom_model (
  input wire logic clk, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic ce, // clock enable seen by the loader
  input wire logic start, // begin a pass from offset 1Ch
  input wire logic slow, // insert random gaps between entries
  input wire logic rom_ready, // loader takes entries
  output logic rom_valid, // entry offered
  output logic [7:0] rom_offset, // entry offset
  output logic [7:0] rom_data // entry byte
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:255];
  logic [7:0] ptr_reg;
  int seed = 83317;
  // ----------------------------------------
  // entry stream
  // ----------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ptr_reg <= 8'h60;
      rom_valid <= 1'b0;
      rom_offset <= 8'h5A;
      rom_data <= 8'hA5;
    end else if (start) begin
      ptr_reg <= 8'h1C;
    end else if (!rom_valid || (ce && rom_ready)) begin
      // ascending offsets, pass ends after the 5Fh entry
      if (ptr_reg <= 8'h5F && !(slow && ($random(seed) % 2 != 0))) begin
        rom_valid <= 1'b1;
        rom_offset <= ptr_reg;
        rom_data <= mem[ptr_reg];
        ptr_reg <= ptr_reg + 8'h01;
      end else begin
        // released lines show no stale value
        rom_valid <= 1'b0;
        rom_offset <= ~rom_offset;
        rom_data <= ~rom_data;
      end
    end
  end
endmodule

// ### testbench.sv
// self-checking bench for the serial ROM config loader
// assumes: srcl_pkg, srcl_loader and srcl_rom_model compiled before
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import srcl_pkg::*;
  typedef struct {string name; logic [31:0] val;} srcl_note_s;
  logic clk, rst_b, ce, ce_rand, start, slow, rd_pend;
  logic rom_valid, rom_ready, wr_en, rd_en, load_done;
  logic [7:0] rom_offset, rom_data, addr;
  logic [31:0] wr_data, rd_data;
  logic [7:0] img [0:255];
  srcl_note_s exp_q[$];
  int seed = 83317;
  int num_errors = 0;
  int num_checks = 0;
  srcl_loader dut_u (.clk(clk), .rst_b(rst_b), .ce(ce), .rom_valid(rom_valid),
    .rom_offset(rom_offset), .rom_data(rom_data), .rom_ready(rom_ready), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .load_done(load_done), .force_evt_b27(), .legacy_id_rev(), .max_lat(), .min_gnt(),
    .unfair_en(), .phy_prog_permit(), .link_enh2(), .accel_en(), .mini_rom_ptr(),
    .mini_rom_present(), .phy_ctrl(), .sc_class(), .sc_ssvid(), .sc_ssid(),
    .sc_gen_ctrl(), .sc_cfg1(), .sc_cfg2());
  srcl_rom_model rom_u (.clk(clk), .rst_b(rst_b), .ce(ce), .start(start), .slow(slow),
    .rom_ready(rom_ready), .rom_valid(rom_valid), .rom_offset(rom_offset),
    .rom_data(rom_data));
  // ----------------------------------------
  // clock, enable and checking
  // ----------------------------------------
  initial clk = 1'b0;
  always #10 clk = ~clk;
  always @(posedge clk) ce <= ce_rand ? ($random(seed) % 4 != 0) : 1'b1;
  always @(posedge clk) rd_pend <= rd_en && ce;
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, seen);
      num_errors++;
    end
  endtask
  // read data stands one cycle after the strobe
  always @(negedge clk) begin
    if (rd_pend) begin
      check(exp_q[0].name, rd_data, exp_q[0].val);
      void'(exp_q.pop_front());
    end
  end
  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #400000;
    num_errors++;
    give_verdict();
  end
  // ----------------------------------------
  // bus and image tasks
  // ----------------------------------------
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input string name);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    exp_q.push_back('{name, e});
    @(posedge clk);
    rd_en <= 1'b0;
  endtask
  task load_image(input logic [7:0] mini, input logic [7:0] endv);
    for (int i = 'h1C; i < 'h5F; i++) img[i] = $random(seed);
    img[8'h22] = 8'h02;
    img[8'h23] = 8'h17;
    img[8'h4F] = 8'h05;
    img[8'h50] = 8'h0E;
    img[8'h5F] = endv;
    img[8'h2A] = mini;
    for (int i = 'h1C; i <= 'h5F; i++) rom_u.mem[i] = img[i];
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
  endtask
  task wait_done;
    int n;
    n = 0;
    ce_rand <= 1'b1;
    while (load_done !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    ce_rand <= 1'b0;
    check("load_done", {31'h0, load_done}, 32'h1);
  endtask
  task check_regs;
    rd(REG_SC_CLASS, {8'h00, img[8'h53], img[8'h52], img[8'h51]}, "sc_class");
    rd(REG_SC_IDS, {img[8'h57], img[8'h56], img[8'h55], img[8'h54]}, "sc_ids");
    rd(REG_SC_CFG1, {img[8'h5C], img[8'h5B], img[8'h5A], img[8'h59]}, "sc_cfg1");
    rd(REG_SC_CFG2, {9'h0, img[8'h58][6:0], img[8'h5E], img[8'h5D]}, "sc_cfg2");
    rd(REG_OHCI, {img[8'h2A] != 8'h00, img[8'h29][7:6], img[8'h29][2:1], 3'h0,
      img[8'h2A], img[8'h3A] & 8'h8A, img[8'h24]}, "ohci");
    rd(REG_LEGACY, {23'h0, img[8'h1C][3], img[8'h1D]}, "legacy");
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {rst_b, ce_rand, start, slow, wr_en, rd_en} = 6'h00;
    addr = 8'h00;
    wr_data = 32'h0000_0000;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rd(REG_LEGACY, 32'h0, "legacy_reset");
    rd(8'h20, 32'h0, "unmapped");
    rd(REG_CTRL, 32'h1, "ctrl_reset");
    wr(REG_CTRL, 32'h0);
    load_image(8'h00, 8'h80);
    repeat (20) @(posedge clk);
    check("rom_ready_full", {31'h0, rom_ready}, 32'h0);
    wr(REG_CTRL, 32'h1);
    wait_done();
    check_regs();
    rd(REG_STATUS, 32'h27, "status");
    $display("test 1 done");
    wr(REG_CTRL, 32'h3);
    repeat (2) @(posedge clk);
    check("done_cleared", {31'h0, load_done}, 32'h0);
    slow <= 1'b1;
    load_image($random(seed) | 8'h01, 8'h80);
    wait_done();
    check_regs();
    $display("test 2 done");
    // let the last read be checked before reset clears the read data
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd(REG_OHCI, 32'h0, "ohci_reset");
    load_image(8'h00, 8'h81);
    repeat (400) @(posedge clk);
    check("no_stop", {31'h0, load_done}, 32'h0);
    rd(REG_STATUS, 32'h1E, "status_bad_end");
    check_regs();
    $display("test 3 done");
    repeat (3) @(posedge clk);
    give_verdict();
  end
endmodule
